// file: rlc_config_regs.sv
// What this block does
// - reference/oscillator register at address seven
// - reference clock from oscillator or divided pin
// - oscillator enable drives conversion clock pin
// - source plus reference power runs oscillator
// - oscillator on if pin or bit high
// - all reference fields reset to zero
// - reference power follows its bit
// - buffer power follows its bit
// - bandgap wins, else two-volt picks level
// - mirrored serial control register at twenty-four
// - each mirrored pair is ORed
// - bit order chosen by low-order-first
// - symmetric write instruction decodes either order
// - two-wire drives data-in pin on reads
// - two-wire read data also on data-out
// - three-wire uses separate in and out
// - early release frees data-in on active edge
// - pin clock divided by one, two, four, eight
`timescale 1ns/1ns
`default_nettype none
`include "rlc_defs.svh"

module rlc_config_regs (
	input wire logic core_clk,
	input wire logic srst,
	input wire logic sclk_pin,
	input wire logic cs_n_pin,
	input wire logic din_pin_i,
	output logic din_pin_o,
	output logic din_pin_oe,
	output logic dout_pin_o,
	output logic dout_pin_oe,
	input wire logic conversion_clock_pin_pin_i,
	output logic conversion_clock_pin_pin_o,
	output logic conversion_clock_pin_pin_oe,
	input wire logic oscillator_force_pin,
	input wire logic [1:0] clock_divider_select,
	output logic ref_clk_tick,
	output logic osc_power_on,
	output logic reference_power_on,
	output logic ref_buffer_power_on,
	output rlc_pkg::rlc_vref_type ref_level,
	output logic low_order_first,
	output logic two_wire_select,
	output logic early_release_select
);
	import rlc_pkg::*;

	// ****************************************
	// helpers
	// ****************************************

	function automatic logic [7:0] shift_in(
		input logic [7:0] cur,
		input logic bit_in,
		input logic lsb_first
	);
		if (lsb_first) begin
			shift_in = {bit_in, cur[7:1]};
		end else begin
			shift_in = {cur[6:0], bit_in};
		end
	endfunction : shift_in

	function automatic rlc_vref_type pick_vref(input rlc_refosc_type ro);
		if (ro.bandgap) begin
			pick_vref = RLC_VREF_1V15;
		end else if (ro.two_volt) begin
			pick_vref = RLC_VREF_2V048;
		end else begin
			pick_vref = RLC_VREF_2V5;
		end
	endfunction : pick_vref

	// read data is picked from the address just received, not the stored one
	function automatic logic [7:0] read_value(input logic [4:0] a, input rlc_refosc_type ro, input rlc_sifc_type sc);
		case (a)
			`RLC_ADDR_REF_OSC: read_value = {2'h0, ro};
			`RLC_ADDR_SIF_CTRL: read_value = {sc.lsb_hi, sc.tw_hi, sc.er_hi, 2'h0,
				sc.er_lo, sc.tw_lo, sc.lsb_lo};
			default: read_value = `RLC_UNMAPPED_READ;
		endcase
	endfunction : read_value

	// ****************************************
	// pin synchronisers
	// ****************************************

	logic [1:0] sclk_sync;
	logic [1:0] cs_n_sync;
	logic [1:0] din_sync;
	logic [1:0] conversion_clock_pin_sync;
	logic [1:0] force_sync;
	logic sclk_prev;
	logic [1:0] next_sclk_sync;
	logic [1:0] next_cs_n_sync;
	logic [1:0] next_din_sync;
	logic [1:0] next_conversion_clock_pin_sync;
	logic [1:0] next_force_sync;

	always_comb begin
		next_sclk_sync = {sclk_sync[0], sclk_pin};
		next_cs_n_sync = {cs_n_sync[0], cs_n_pin};
		next_din_sync = {din_sync[0], din_pin_i};
		next_conversion_clock_pin_sync = {conversion_clock_pin_sync[0], conversion_clock_pin_pin_i};
		next_force_sync = {force_sync[0], oscillator_force_pin};
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			sclk_sync <= 2'h0;
			cs_n_sync <= 2'h3;
			din_sync <= 2'h0;
			conversion_clock_pin_sync <= 2'h0;
			force_sync <= 2'h0;
			sclk_prev <= 1'b0;
		end else begin
			sclk_sync <= next_sclk_sync;
			cs_n_sync <= next_cs_n_sync;
			din_sync <= next_din_sync;
			conversion_clock_pin_sync <= next_conversion_clock_pin_sync;
			force_sync <= next_force_sync;
			sclk_prev <= sclk_sync[1];
		end
	end

	logic cs_active;
	logic sclk_rise;
	logic sclk_fall;

	// rising sclk is the active edge, falling the inactive one
	assign cs_active = !cs_n_sync[1];
	assign sclk_rise = cs_active && sclk_sync[1] && !sclk_prev;
	assign sclk_fall = cs_active && !sclk_sync[1] && sclk_prev;

	// ****************************************
	// registers
	// ****************************************

	rlc_refosc_type refosc;
	rlc_sifc_type sifc;
	logic lsb_eff;
	logic tw_eff;
	logic er_eff;

	assign lsb_eff = sifc.lsb_hi | sifc.lsb_lo;
	assign tw_eff = sifc.tw_hi | sifc.tw_lo;
	assign er_eff = sifc.er_hi | sifc.er_lo;

	// ****************************************
	// serial engine
	// ****************************************

	rlc_state_type state;
	rlc_state_type next_state;
	logic [7:0] shreg;
	logic [7:0] next_shreg;
	logic [2:0] bit_cnt;
	logic [2:0] next_bit_cnt;
	logic [4:0] addr;
	logic [4:0] next_addr;
	logic [7:0] tx_reg;
	logic [7:0] next_tx_reg;
	logic [7:0] rx_byte;
	logic byte_done;
	logic wr_commit;

	always_comb begin
		next_state = state;
		next_shreg = shreg;
		next_bit_cnt = bit_cnt;
		next_addr = addr;
		next_tx_reg = tx_reg;
		rx_byte = shift_in(shreg, din_sync[1], lsb_eff);
		byte_done = sclk_rise && (bit_cnt == 3'h7);
		wr_commit = 1'b0;
		if (!cs_active) begin
			next_state = RLC_ST_CMD;
			next_bit_cnt = 3'h0;
		end else begin
			if (sclk_rise) begin
				next_bit_cnt = bit_cnt + 3'h1;
				next_shreg = rx_byte;
			end
			if (sclk_fall && state == RLC_ST_RD) begin
				if (lsb_eff) begin
					next_tx_reg = {1'b0, tx_reg[7:1]};
				end else begin
					next_tx_reg = {tx_reg[6:0], 1'b0};
				end
			end
			case (state)
				RLC_ST_CMD: begin
					if (byte_done) begin
						next_addr = rx_byte[`RLC_INS_ADDR_MSB:0];
						if (rx_byte[`RLC_INS_READ_BIT]) begin
							next_state = RLC_ST_RD;
						end else begin
							next_state = RLC_ST_WR;
						end
					end
				end
				RLC_ST_WR: begin
					if (byte_done) begin
						wr_commit = 1'b1;
						next_state = RLC_ST_CMD;
					end
				end
				RLC_ST_RD: begin
					if (byte_done) begin
						next_state = RLC_ST_CMD;
					end
				end
				default: begin
					next_state = RLC_ST_CMD;
				end
			endcase
		end
		if (state == RLC_ST_CMD && next_state == RLC_ST_RD) begin
			next_tx_reg = read_value(next_addr, refosc, sifc);
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			state <= RLC_ST_CMD;
			shreg <= 8'h00;
			bit_cnt <= 3'h0;
			addr <= 5'h00;
			tx_reg <= 8'h00;
		end else begin
			state <= next_state;
			shreg <= next_shreg;
			bit_cnt <= next_bit_cnt;
			addr <= next_addr;
			tx_reg <= next_tx_reg;
		end
	end

	// ****************************************
	// register writes and derived controls
	// ****************************************

	rlc_refosc_type next_refosc;
	rlc_sifc_type next_sifc;
	logic next_osc_power_on;

	always_comb begin
		next_refosc = refosc;
		next_sifc = sifc;
		if (wr_commit && addr == `RLC_ADDR_REF_OSC) begin
			// reserved bits seven-six are dropped
			next_refosc = rlc_refosc_type'(rx_byte[5:0]);
		end
		if (wr_commit && addr == `RLC_ADDR_SIF_CTRL) begin
			// new order takes effect from the next byte
			next_sifc.lsb_hi = rx_byte[`RLC_SC_LSB_HI];
			next_sifc.tw_hi = rx_byte[`RLC_SC_TW_HI];
			next_sifc.er_hi = rx_byte[`RLC_SC_ER_HI];
			next_sifc.er_lo = rx_byte[`RLC_SC_ER_LO];
			next_sifc.tw_lo = rx_byte[`RLC_SC_TW_LO];
			next_sifc.lsb_lo = rx_byte[`RLC_SC_LSB_LO];
		end
		// source select alone already covers source plus reference power
		next_osc_power_on = force_sync[1] | next_refosc.osc_oe | next_refosc.src_sel;
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			refosc <= `RLC_RO_RESET;
			sifc <= `RLC_SC_RESET;
			osc_power_on <= 1'b0;
			conversion_clock_pin_pin_oe <= 1'b0;
			reference_power_on <= 1'b0;
			ref_buffer_power_on <= 1'b0;
			ref_level <= RLC_VREF_2V5;
			low_order_first <= 1'b0;
			two_wire_select <= 1'b0;
			early_release_select <= 1'b0;
		end else begin
			refosc <= next_refosc;
			sifc <= next_sifc;
			osc_power_on <= next_osc_power_on;
			conversion_clock_pin_pin_oe <= next_refosc.osc_oe;
			reference_power_on <= next_refosc.ref_pwr;
			ref_buffer_power_on <= next_refosc.buf_pwr;
			ref_level <= pick_vref(next_refosc);
			low_order_first <= next_sifc.lsb_hi | next_sifc.lsb_lo;
			two_wire_select <= next_sifc.tw_hi | next_sifc.tw_lo;
			early_release_select <= next_sifc.er_hi | next_sifc.er_lo;
		end
	end

	// ****************************************
	// data pin drivers
	// ****************************************

	logic drive;
	logic next_drive;
	logic out_bit;
	logic next_out_bit;

	always_comb begin
		next_drive = drive;
		next_out_bit = out_bit;
		if (!cs_active) begin
			next_drive = 1'b0;
		end else if (sclk_fall && state == RLC_ST_RD) begin
			next_drive = 1'b1;
			next_out_bit = lsb_eff ? tx_reg[0] : tx_reg[7];
		end else if (sclk_fall) begin
			next_drive = 1'b0;
		end else if (byte_done && state == RLC_ST_RD && er_eff) begin
			// frees the line before an early host drives it again
			next_drive = 1'b0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			drive <= 1'b0;
			out_bit <= 1'b0;
			din_pin_o <= 1'b0;
			din_pin_oe <= 1'b0;
			dout_pin_o <= 1'b0;
			dout_pin_oe <= 1'b0;
		end else begin
			drive <= next_drive;
			out_bit <= next_out_bit;
			din_pin_o <= next_out_bit;
			din_pin_oe <= next_drive && tw_eff;
			dout_pin_o <= next_out_bit;
			dout_pin_oe <= next_drive;
		end
	end

	// ****************************************
	// reference clocking
	// ****************************************

	rlc_ref_clock u_ref_clock (
		.core_clk(core_clk),
		.srst(srst),
		.osc_on(osc_power_on),
		.ref_from_osc(refosc.src_sel),
		.conversion_clock_pin_sync(conversion_clock_pin_sync[1]),
		.div_sel(clock_divider_select),
		.osc_wave(conversion_clock_pin_pin_o),
		.ref_clk_tick(ref_clk_tick)
	);

endmodule : rlc_config_regs
`default_nettype wire

// file: rlc_defs.svh
`ifndef RLC_DEFS_SVH
`define RLC_DEFS_SVH

// register addresses on the serial link
`define RLC_ADDR_REF_OSC 5'h07
`define RLC_ADDR_SIF_CTRL 5'h18

// instruction byte fields
`define RLC_INS_READ_BIT 6
`define RLC_INS_ADDR_MSB 4

// reference/oscillator register fields
`define RLC_RO_SRC_BIT 5
`define RLC_RO_OSCOE_BIT 4
`define RLC_RO_REFPWR_BIT 3
`define RLC_RO_BUFPWR_BIT 2
`define RLC_RO_TWOV_BIT 1
`define RLC_RO_BANDGAP_BIT 0
`define RLC_RO_RESET 6'h00

// serial interface control fields, mirrored pairs
`define RLC_SC_LSB_HI 7
`define RLC_SC_TW_HI 6
`define RLC_SC_ER_HI 5
`define RLC_SC_ER_LO 2
`define RLC_SC_TW_LO 1
`define RLC_SC_LSB_LO 0
`define RLC_SC_RESET 6'h00

// answer to a read of an unmapped address
`define RLC_UNMAPPED_READ 8'h00

// internal oscillator timing
`define RLC_CORE_FREQ_KHZ 100000
`define RLC_OSC_FREQ_KHZ 2500
`define RLC_OSC_HALF_CYCLES (`RLC_CORE_FREQ_KHZ / (2 * `RLC_OSC_FREQ_KHZ))

`endif

// file: rlc_pkg.sv
package rlc_pkg;

	typedef struct packed {
		logic src_sel;
		logic osc_oe;
		logic ref_pwr;
		logic buf_pwr;
		logic two_volt;
		logic bandgap;
	} rlc_refosc_type;

	typedef struct packed {
		logic lsb_hi;
		logic tw_hi;
		logic er_hi;
		logic er_lo;
		logic tw_lo;
		logic lsb_lo;
	} rlc_sifc_type;

	typedef enum logic [1:0] {
		RLC_VREF_2V5 = 2'h0,
		RLC_VREF_2V048 = 2'h1,
		RLC_VREF_1V15 = 2'h2
	} rlc_vref_type;

	typedef enum logic [2:0] {
		RLC_ST_CMD = 3'h1,
		RLC_ST_WR = 3'h2,
		RLC_ST_RD = 3'h4
	} rlc_state_type;

endpackage : rlc_pkg

// file: rlc_ref_clock.sv
`timescale 1ns/1ns
`default_nettype none
`include "rlc_defs.svh"

module rlc_ref_clock #(
	parameter int unsigned HALF_CYCLES = `RLC_OSC_HALF_CYCLES
) (
	input wire logic core_clk,
	input wire logic srst,
	input wire logic osc_on,
	input wire logic ref_from_osc,
	input wire logic conversion_clock_pin_sync,
	input wire logic [1:0] div_sel,
	output logic osc_wave,
	output logic ref_clk_tick
);
	import rlc_pkg::*;

	logic [7:0] osc_cnt;
	logic [7:0] next_osc_cnt;
	logic next_osc_wave;
	logic conversion_clock_pin_prev;
	logic [2:0] div_cnt;
	logic [2:0] next_div_cnt;
	logic next_ref_clk_tick;
	logic [2:0] div_mask;
	logic conversion_clock_pin_rise;

	always_comb begin
		next_osc_cnt = osc_cnt;
		next_osc_wave = osc_wave;
		next_div_cnt = div_cnt;
		next_ref_clk_tick = 1'b0;
		div_mask = 3'((4'h1 << div_sel) - 4'h1);
		conversion_clock_pin_rise = conversion_clock_pin_sync && !conversion_clock_pin_prev;
		// oscillator stops low when nobody asks for it
		if (!osc_on) begin
			next_osc_cnt = 8'h00;
			next_osc_wave = 1'b0;
		end else if (osc_cnt == 8'(HALF_CYCLES - 1)) begin
			next_osc_cnt = 8'h00;
			next_osc_wave = !osc_wave;
		end else begin
			next_osc_cnt = osc_cnt + 8'h01;
		end
		if (conversion_clock_pin_rise) begin
			next_div_cnt = div_cnt + 3'h1;
		end
		if (ref_from_osc) begin
			next_ref_clk_tick = osc_on && !osc_wave && next_osc_wave;
		end else begin
			next_ref_clk_tick = conversion_clock_pin_rise && ((div_cnt & div_mask) == div_mask);
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			osc_cnt <= 8'h00;
			osc_wave <= 1'b0;
			conversion_clock_pin_prev <= 1'b0;
			div_cnt <= 3'h0;
			ref_clk_tick <= 1'b0;
		end else begin
			osc_cnt <= next_osc_cnt;
			osc_wave <= next_osc_wave;
			conversion_clock_pin_prev <= conversion_clock_pin_sync;
			div_cnt <= next_div_cnt;
			ref_clk_tick <= next_ref_clk_tick;
		end
	end

endmodule : rlc_ref_clock
`default_nettype wire

// file: rlc_config_regs_sva.sv
`timescale 1ns/1ns
`default_nettype none
module rlc_config_regs_sva (
	input wire logic core_clk,
	input wire logic srst,
	input wire logic sclk_pin,
	input wire logic cs_n_pin,
	input wire logic oscillator_force_pin,
	input wire logic din_pin_o,
	input wire logic din_pin_oe,
	input wire logic dout_pin_o,
	input wire logic dout_pin_oe,
	input wire logic conversion_clock_pin_pin_o,
	input wire logic conversion_clock_pin_pin_oe,
	input wire logic ref_clk_tick,
	input wire logic osc_power_on,
	input wire logic two_wire_select
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (srst);
	// ****
	// pin and oscillator
	// ****
	property p_oe_osc;
		conversion_clock_pin_pin_oe [*2] |-> osc_power_on;
	endproperty
	a_oe_osc: assert property (p_oe_osc) else $error("pin driven, oscillator off");
	property p_force;
		oscillator_force_pin [*5] |-> osc_power_on;
	endproperty
	a_force: assert property (p_force) else $error("force pin ignored");
	// a wave stopped by power-off is allowed to end its high phase early
	property p_wave;
		$rose(conversion_clock_pin_pin_o) |-> (conversion_clock_pin_pin_o [*8]) or (##[1:8] !osc_power_on);
	endproperty
	a_wave: assert property (p_wave) else $error("oscillator high phase short");
	property p_tick;
		ref_clk_tick |=> !ref_clk_tick;
	endproperty
	a_tick: assert property (p_tick) else $error("tick wider than one cycle");
	// ****
	// serial data pins
	// ****
	property p_din_2w;
		din_pin_oe |-> two_wire_select;
	endproperty
	a_din_2w: assert property (p_din_2w) else $error("data-in driven in three-wire");
	property p_mirror;
		din_pin_oe |-> dout_pin_oe && (din_pin_o == dout_pin_o);
	endproperty
	a_mirror: assert property (p_mirror) else $error("data-in and data-out differ");
	property p_cs_rel;
		cs_n_pin [*6] |-> !din_pin_oe && !dout_pin_oe;
	endproperty
	a_cs_rel: assert property (p_cs_rel) else $error("pin held after deselect");
	property p_hold;
		(dout_pin_oe && sclk_pin) [*6] |-> $stable(dout_pin_o);
	endproperty
	a_hold: assert property (p_hold) else $error("read bit moved while clock high");
	c_2w: cover property ($rose(two_wire_select));
	c_early: cover property ($fell(din_pin_oe) && sclk_pin);
	c_osc: cover property (conversion_clock_pin_pin_oe && ref_clk_tick);
endmodule : rlc_config_regs_sva
bind rlc_config_regs rlc_config_regs_sva u_sva (
	.core_clk(core_clk),
	.srst(srst),
	.sclk_pin(sclk_pin),
	.cs_n_pin(cs_n_pin),
	.oscillator_force_pin(oscillator_force_pin),
	.din_pin_o(din_pin_o),
	.din_pin_oe(din_pin_oe),
	.dout_pin_o(dout_pin_o),
	.dout_pin_oe(dout_pin_oe),
	.conversion_clock_pin_pin_o(conversion_clock_pin_pin_o),
	.conversion_clock_pin_pin_oe(conversion_clock_pin_pin_oe),
	.ref_clk_tick(ref_clk_tick),
	.osc_power_on(osc_power_on),
	.two_wire_select(two_wire_select)
);
`default_nettype wire

// file: rlc_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module rlc_host_model (
	input wire logic core_clk,
	input wire logic din_wire,
	input wire logic dout,
	input wire logic din_drv,
	output logic sclk,
	output logic cs_n,
	output logic din,
	output logic din_oe
);
	logic lsb_mode = 1'b0;
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		din = 1'b0;
		din_oe = 1'b0;
	end
	// ****
	// serial master
	// ****
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask : cyc
	// 8 cycles per half bit keeps sampling well past the 3-cycle answer
	task automatic xfer(input logic [7:0] tx, input logic rd, output logic [7:0] rw, output logic [7:0] ro,
		output logic eoe);
		int k;
		for (int i = 0; i < 8; i++) begin
			k = lsb_mode ? i : 7 - i;
			din = tx[k];
			din_oe = !rd;
			cyc(8);
			sclk = 1'b1;
			rw[k] = din_wire;
			ro[k] = dout;
			cyc(7);
			eoe = din_drv;
			cyc(1);
			sclk = 1'b0;
		end
	endtask : xfer
	task automatic access(input logic [4:0] a, input logic wr, input logic [7:0] d, output logic [7:0] rw,
		output logic [7:0] ro, output logic eoe);
		logic [7:0] u;
		logic e;
		cs_n = 1'b0;
		cyc(4);
		xfer({1'b0, !wr, 1'b0, a}, 1'b0, u, u, e);
		xfer(wr ? d : 8'h00, !wr, rw, ro, eoe);
		cyc(8);
		cs_n = 1'b1;
		cyc(8);
	endtask : access
endmodule : rlc_host_model
`default_nettype wire

// file: tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	import rlc_pkg::*;
	logic core_clk, srst, force_pin, sclk, cs_n, host_din, host_oe, din_o, din_oe, dout_o, dout_oe, conversion_clock_pin_o;
	logic conversion_clock_pin_oe, tick, osc_on, refp, bufp, lsbf, tw, er, eoe, conversion_clock_pin_in = 1'b0, float_q = 1'b0, conversion_clock_pin_q = 1'b0;
	logic din_wire, dout_wire, conversion_clock_pin_wire;
	logic [1:0] div_sel;
	logic [7:0] rw, ro, v, s, e;
	logic [4:0] a;
	rlc_vref_type lvl;
	int err_total = 0, tests_run = 0, seed, ncyc = 0, nticks = 0, n, nrise = 0;
	logic [7:0] pats [7] = '{8'h80, 8'h01, 8'h42, 8'h46, 8'h61, 8'h20, 8'h00};
	// released lines toggle so a stale level never reads as data
	assign din_wire = din_oe ? din_o : (host_oe ? host_din : float_q);
	assign dout_wire = dout_oe ? dout_o : float_q;
	assign conversion_clock_pin_wire = conversion_clock_pin_oe ? conversion_clock_pin_o : conversion_clock_pin_in;
	rlc_config_regs dut (
		.core_clk(core_clk),
		.srst(srst),
		.sclk_pin(sclk),
		.cs_n_pin(cs_n),
		.din_pin_i(din_wire),
		.din_pin_o(din_o),
		.din_pin_oe(din_oe),
		.dout_pin_o(dout_o),
		.dout_pin_oe(dout_oe),
		.conversion_clock_pin_pin_i(conversion_clock_pin_wire),
		.conversion_clock_pin_pin_o(conversion_clock_pin_o),
		.conversion_clock_pin_pin_oe(conversion_clock_pin_oe),
		.oscillator_force_pin(force_pin),
		.clock_divider_select(div_sel),
		.ref_clk_tick(tick),
		.osc_power_on(osc_on),
		.reference_power_on(refp),
		.ref_buffer_power_on(bufp),
		.ref_level(lvl),
		.low_order_first(lsbf),
		.two_wire_select(tw),
		.early_release_select(er)
	);
	rlc_host_model host (.core_clk(core_clk), .din_wire(din_wire), .dout(dout_wire), .din_drv(din_oe),
		.sclk(sclk), .cs_n(cs_n), .din(host_din), .din_oe(host_oe));
	// ****
	// checking
	// ****
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk
	function automatic logic [7:0] exp_out(input logic [7:0] v, input logic [7:0] s);
		return {s[7] | s[0], s[6] | s[1], s[5] | s[2], v[3], v[2], v[4], v[0] ? 2'h2 : {1'b0, v[1]}};
	endfunction : exp_out
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : give_verdict
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		ncyc++;
		float_q <= ~float_q;
		conversion_clock_pin_in <= #1 ncyc[2];
		if (tick === 1'b1)
			nticks++;
		conversion_clock_pin_q <= conversion_clock_pin_o;
		if (conversion_clock_pin_o === 1'b1 && conversion_clock_pin_q === 1'b0)
			nrise++;
		if (ncyc == 30000) begin
			err_total++;
			give_verdict();
		end
	end
	// ****
	// stimulus
	// ****
	initial begin
		seed = 84136;
		srst = 1'b1;
		force_pin = 1'b0;
		div_sel = 2'h0;
		repeat (5) @(posedge core_clk);
		#1;
		srst = 1'b0;
		host.cyc(4);
		host.access(5'h07, 1'b0, 8'h00, rw, ro, eoe);
		chk(ro, 8'h00);
		host.access(5'h18, 1'b0, 8'h00, rw, ro, eoe);
		chk(ro, 8'h00);
		chk({lsbf, tw, er, refp, bufp, conversion_clock_pin_oe, lvl}, 8'h00);
		chk({7'h00, osc_on}, 8'h00);
		$display("end reset");
		for (int i = 0; i < 12; i++) begin
			v = (i == 0) ? 8'h28 : (i == 1) ? 8'h03 : 8'($random(seed)) & 8'h3F;
			force_pin = (i > 1) ? 1'($random(seed)) : 1'b0;
			host.access(5'h07, 1'b1, v, rw, ro, eoe);
			host.access(5'h07, 1'b0, 8'h00, rw, ro, eoe);
			chk(ro, v);
			chk({lsbf, tw, er, refp, bufp, conversion_clock_pin_oe, lvl}, exp_out(v, 8'h00));
			chk({7'h00, osc_on}, {7'h00, force_pin | v[4] | v[5]});
		end
		host.access(5'h05, 1'b1, 8'hFF, rw, ro, eoe);
		host.access(5'h05, 1'b0, 8'h00, rw, ro, eoe);
		chk(ro, 8'h00);
		chk({lsbf, tw, er, refp, bufp, conversion_clock_pin_oe, lvl}, exp_out(v, 8'h00));
		$display("end reference register");
		for (int i = 0; i < 10; i++) begin
			s = (i < 7) ? pats[i] : 8'($random(seed)) & 8'hE7;
			host.access(5'h18, 1'b1, s, rw, ro, eoe);
			host.lsb_mode = s[7] | s[0];
			a = i[0] ? 5'h18 : 5'h07;
			e = i[0] ? s : v;
			host.access(a, 1'b0, 8'h00, rw, ro, eoe);
			chk(ro, e);
			chk({lsbf, tw, er, refp, bufp, conversion_clock_pin_oe, lvl}, exp_out(v, s));
			chk({7'h00, eoe}, {7'h00, (s[6] | s[1]) & !(s[5] | s[2])});
			if (s[6] | s[1])
				chk(rw, e);
		end
		host.access(5'h18, 1'b1, 8'h00, rw, ro, eoe);
		host.lsb_mode = 1'b0;
		$display("end serial control");
		host.access(5'h07, 1'b1, 8'h00, rw, ro, eoe);
		force_pin = 1'b0;
		for (int d = 0; d < 5; d++) begin
			if (d == 4)
				host.access(5'h07, 1'b1, 8'h20, rw, ro, eoe);
			div_sel = 2'(d);
			host.cyc(16);
			nticks = 0;
			nrise = 0;
			host.cyc(640);
			n = (d == 4) ? 16 : 80 >> d;
			chk({7'h00, 1'(nticks >= n - 1 && nticks <= n + 1)}, 8'h01);
			chk({7'h00, 1'(nrise >= ((d == 4) ? 15 : 0) && nrise <= ((d == 4) ? 17 : 0))}, 8'h01);
		end
		$display("end reference clock");
		give_verdict();
	end
endmodule : tb_top
`default_nettype wire
